// ==== aptc_pkg.sv ====
// Package for the converter pair trigger control block
`default_nettype none
package aptc_pkg;
  localparam int NUM_PAIRS = 4;
  localparam int ADDR_W    = 4;
  localparam int DATA_W    = 16;
  // Register indices
  localparam logic [3:0] OFS_CTL_LOWER = 4'h0;
  localparam logic [3:0] OFS_CTL_UPPER = 4'h1;
  localparam logic [3:0] OFS_READY     = 4'h2;
  localparam logic [3:0] OFS_IRQ_STAT  = 4'h3;
  localparam logic [3:0] OFS_IRQ_MASK  = 4'h4;
  localparam logic [3:0] OFS_STATUS    = 4'h5;
  // Field positions inside one control byte
  localparam int FLD_IRQ_EN  = 7;
  localparam int FLD_WAITING = 6;
  localparam int FLD_KICK    = 5;
  localparam int FLD_SEL_LSB = 0;
  localparam int FLD_SEL_W   = 5;
  // Reset values
  localparam logic [15:0] RST_CTL   = 16'h0000;
  localparam logic [3:0]  RST_FLAGS = 4'h0;
  // Selector codes
  localparam logic [4:0] SEL_OFF        = 5'h00;
  localparam logic [4:0] SEL_SOFT_OWN   = 5'h01;
  localparam logic [4:0] SEL_SOFT_GLOB  = 5'h02;
  localparam logic [4:0] SEL_PWM_SPEC   = 5'h03;
  localparam logic [4:0] SEL_PRI_FIRST  = 5'h04;
  localparam logic [4:0] SEL_PRI_LAST   = 5'h0b;
  localparam logic [4:0] SEL_TMR1       = 5'h0c;
  localparam logic [4:0] SEL_PWM_SEC    = 5'h0d;
  localparam logic [4:0] SEL_SEC_FIRST  = 5'h0e;
  localparam logic [4:0] SEL_SEC_LAST   = 5'h16;
  localparam logic [4:0] SEL_CL_FIRST   = 5'h17;
  localparam logic [4:0] SEL_CL_LAST    = 5'h1e;
  localparam logic [4:0] SEL_TMR2       = 5'h1f;

  typedef struct packed {
    logic       irq_enable;
    logic       waiting;
    logic       soft_kick;
    logic [4:0] start_select;
  } aptc_pair_ctl_type;

  typedef struct packed {
    logic       soft_global;
    logic       pwm_special;
    logic       pwm_sec_special;
    logic [7:0] pwm_primary;
    logic [8:0] pwm_secondary;
    logic [7:0] pwm_cur_limit;
    logic       timer1_match;
    logic       timer2_match;
  } aptc_trig_type;

  typedef enum logic [2:0] {
    ENG_IDLE  = 3'b001,
    ENG_START = 3'b010,
    ENG_BUSY  = 3'b100
  } aptc_eng_state_type;
endpackage
`default_nettype wire

// ==== aptc_top.sv ====
// Trigger selection and request tracking for four converter pairs
// Functional notes
// - Per-pair control byte, enable/waiting/kick/select
// - Done raises request only when enabled
// - Waiting set on trigger, cleared when done
// - Kick starts only software pick; cleared on waiting
// - Held request runs once engine frees
// - Select zero disables the pair
// - Codes one/two pick own/global software kick
// - Code three picks PWM special event
// - Code thirteen picks PWM secondary special event
// - Codes four to eleven pick primaries
// - Codes fourteen to twenty-two pick secondaries
// - Codes twenty-three to thirty pick current limits
// - Code twelve timer one, all-ones timer two
// - Result ready set on data, zero-write clears
//
// The address map and strobed register access were decided locally.
`default_nettype none
module aptc_top (
  input  wire logic                  clk_i,
  input  wire logic                  nrst_i,
  input  wire logic [3:0]            reg_addr_i,
  input  wire logic [15:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic [15:0]                reg_rdata_o,
  input  wire aptc_pkg::aptc_trig_type trig_i,
  input  wire logic                  eng_busy_i,
  input  wire logic                  eng_done_i,
  output logic                       eng_start_o,
  output logic [1:0]                 eng_pair_o,
  output logic [3:0]                 pair_irq_o,
  output logic                       irq_o
);

  aptc_pkg::aptc_pair_ctl_type ctl_q [4];
  logic [3:0]  ready_q;
  logic [3:0]  stat_q;
  logic [3:0]  mask_q;
  logic [3:0]  hit;
  logic [3:0]  pick;
  logic [3:0]  wr_sel;
  logic [7:0]  wbyte [4];
  logic [1:0]  cur_q;
  logic        any_pick;
  logic [1:0]  pick_idx;
  aptc_pkg::aptc_eng_state_type state_q;

  // Selector decode, shared by all pairs
  function automatic logic trig_hit(input logic [4:0] sel,
                                    input logic kick,
                                    input aptc_pkg::aptc_trig_type t);
    logic [4:0] off;
    off = 5'h00;
    trig_hit = 1'b0;
    if (sel == aptc_pkg::SEL_OFF) begin
      trig_hit = 1'b0;
    end else if (sel == aptc_pkg::SEL_SOFT_OWN) begin
      trig_hit = kick;
    end else if (sel == aptc_pkg::SEL_SOFT_GLOB) begin
      trig_hit = kick | t.soft_global;
    end else if (sel == aptc_pkg::SEL_PWM_SPEC) begin
      trig_hit = t.pwm_special;
    end else if (sel <= aptc_pkg::SEL_PRI_LAST) begin
      off = sel - aptc_pkg::SEL_PRI_FIRST;
      trig_hit = t.pwm_primary[off[2:0]];
    end else if (sel == aptc_pkg::SEL_TMR1) begin
      trig_hit = t.timer1_match;
    end else if (sel == aptc_pkg::SEL_PWM_SEC) begin
      trig_hit = t.pwm_sec_special;
    end else if (sel <= aptc_pkg::SEL_SEC_LAST) begin
      off = sel - aptc_pkg::SEL_SEC_FIRST;
      trig_hit = t.pwm_secondary[off[3:0]];
    end else if (sel <= aptc_pkg::SEL_CL_LAST) begin
      off = sel - aptc_pkg::SEL_CL_FIRST;
      trig_hit = t.pwm_cur_limit[off[2:0]];
    end else begin
      trig_hit = t.timer2_match;
    end
  endfunction

  function automatic logic [7:0] pack_ctl(
      input aptc_pkg::aptc_pair_ctl_type c);
    pack_ctl = {c.irq_enable, c.waiting, c.soft_kick, c.start_select};
  endfunction

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      hit[i]  = trig_hit(ctl_q[i].start_select, ctl_q[i].soft_kick,
                         trig_i);
      pick[i] = ctl_q[i].waiting;
      // Two pairs share each control word, one byte each
      wr_sel[i] = reg_wr_i &&
                  reg_addr_i == ((i < 2) ? aptc_pkg::OFS_CTL_LOWER
                                         : aptc_pkg::OFS_CTL_UPPER);
      wbyte[i]  = (i % 2 == 1) ? reg_wdata_i[15:8] : reg_wdata_i[7:0];
    end
  end

  // Lowest numbered waiting pair wins
  always_comb begin
    any_pick = 1'b0;
    pick_idx = 2'd0;
    for (int i = 3; i >= 0; i--) begin
      if (pick[i]) begin
        any_pick = 1'b1;
        pick_idx = 2'(i);
      end
    end
  end

  logic done_now;
  assign done_now = (state_q == aptc_pkg::ENG_BUSY) && eng_done_i;

  // Control bytes; waiting set beats kick write, done clears own pair
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 4; i++) begin
        ctl_q[i] <= aptc_pkg::aptc_pair_ctl_type'(aptc_pkg::RST_CTL[7:0]);
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_sel[i]) begin
          ctl_q[i].irq_enable   <= wbyte[i][aptc_pkg::FLD_IRQ_EN];
          ctl_q[i].start_select <= wbyte[i][4:0];
          ctl_q[i].soft_kick    <= wbyte[i][aptc_pkg::FLD_KICK];
        end
        // Waiting is hardware owned; a write cannot fake a request
        if (hit[i]) begin
          ctl_q[i].waiting   <= 1'b1;
          ctl_q[i].soft_kick <= 1'b0;
        end else if (done_now && cur_q == 2'(i)) begin
          ctl_q[i].waiting <= 1'b0;
        end
      end
    end
  end

  // Engine sequencing; a trigger while busy just stays waiting
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_q     <= aptc_pkg::ENG_IDLE;
      cur_q       <= 2'd0;
      eng_start_o <= 1'b0;
    end else begin
      eng_start_o <= 1'b0;
      case (state_q)
        aptc_pkg::ENG_IDLE: begin
          if (any_pick && !eng_busy_i) begin
            cur_q       <= pick_idx;
            eng_start_o <= 1'b1;
            state_q     <= aptc_pkg::ENG_START;
          end
        end
        aptc_pkg::ENG_START: begin
          state_q <= aptc_pkg::ENG_BUSY;
        end
        aptc_pkg::ENG_BUSY: begin
          if (eng_done_i) begin
            state_q <= aptc_pkg::ENG_IDLE;
          end
        end
        default: state_q <= aptc_pkg::ENG_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      eng_pair_o <= 2'd0;
    end else begin
      eng_pair_o <= (any_pick && state_q == aptc_pkg::ENG_IDLE)
                    ? pick_idx : cur_q;
    end
  end

  // Per-pair done request pulse
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pair_irq_o <= aptc_pkg::RST_FLAGS;
    end else begin
      for (int i = 0; i < 4; i++) begin
        pair_irq_o[i] <= done_now && cur_q == 2'(i) &&
                         ctl_q[i].irq_enable;
      end
    end
  end

  // Result ready: set wins over a zero write
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ready_q <= aptc_pkg::RST_FLAGS;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (done_now && cur_q == 2'(i)) begin
          ready_q[i] <= 1'b1;
        end else if (reg_wr_i && reg_addr_i == aptc_pkg::OFS_READY &&
                     !reg_wdata_i[i]) begin
          ready_q[i] <= 1'b0;
        end
      end
    end
  end

  // Sticky status cleared by read; new event beats the clear
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      stat_q <= aptc_pkg::RST_FLAGS;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (done_now && cur_q == 2'(i) && ctl_q[i].irq_enable) begin
          stat_q[i] <= 1'b1;
        end else if (reg_rd_i && reg_addr_i == aptc_pkg::OFS_IRQ_STAT) begin
          stat_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      mask_q <= aptc_pkg::RST_FLAGS;
    end else if (reg_wr_i && reg_addr_i == aptc_pkg::OFS_IRQ_MASK) begin
      mask_q <= reg_wdata_i[3:0];
    end
  end

  // Level interrupt, registered, so it lags status by a cycle
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(stat_q & mask_q);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        aptc_pkg::OFS_CTL_LOWER:
          reg_rdata_o <= {pack_ctl(ctl_q[1]), pack_ctl(ctl_q[0])};
        aptc_pkg::OFS_CTL_UPPER:
          reg_rdata_o <= {pack_ctl(ctl_q[3]), pack_ctl(ctl_q[2])};
        aptc_pkg::OFS_READY:    reg_rdata_o <= {12'h000, ready_q};
        aptc_pkg::OFS_IRQ_STAT: reg_rdata_o <= {12'h000, stat_q};
        aptc_pkg::OFS_IRQ_MASK: reg_rdata_o <= {12'h000, mask_q};
        aptc_pkg::OFS_STATUS:
          reg_rdata_o <= {11'h000, cur_q, state_q};
        default:                reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

endmodule
`default_nettype wire

// ==== aptc_props.sv ====
// Port checker for the pair trigger control block
`default_nettype none
module aptc_props (
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        reg_rd_i,
  input wire logic        reg_wr_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        eng_busy_i,
  input wire logic        eng_done_i,
  input wire logic        eng_start_o,
  input wire logic [1:0]  eng_pair_o,
  input wire logic [3:0]  pair_irq_o,
  input wire logic        irq_o
);
  logic [1:0] cur_q;
  // Pair under conversion, to tie each done request to its pair
  always_ff @(posedge clk_i)
    if (!nrst_i) cur_q <= 2'h0;
    else if (eng_start_o) cur_q <= eng_pair_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  start_spacing_a: assert property (eng_start_o |=> !eng_start_o [*3])
    else $error("start pulses too close");
  start_idle_a: assert property (eng_start_o |-> !$past(eng_busy_i))
    else $error("start while engine busy");
  rd_quiet_a: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
    else $error("read data outside read slot");
  irq_pulse_a: assert property (|pair_irq_o |=> pair_irq_o == 4'h0)
    else $error("pair request longer than one cycle");
  irq_cause_a: assert property (|pair_irq_o |-> $past(eng_done_i))
    else $error("pair request without done");
  irq_pair_a: assert property (|pair_irq_o |-> pair_irq_o == 4'h1 << cur_q)
    else $error("pair request on wrong pair");
  irq_fall_a: assert property ($fell(irq_o) |->
    $past(reg_rd_i | reg_wr_i, 2))
    else $error("interrupt dropped without access");
  irq_rise_a: assert property ($rose(irq_o) |->
    $past(|pair_irq_o) || $past(reg_wr_i, 2))
    else $error("interrupt rose without cause");
endmodule
bind aptc_top aptc_props i_props (.*);
`default_nettype wire

// ==== aptc_eng_model.sv ====
// Behavioural shared conversion engine
`default_nettype none
module aptc_eng_model (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       start_i,
  input  wire logic       hold_i,
  input  wire logic [7:0] lat_i,
  output logic            busy_o,
  output logic            done_o
);
  logic [7:0] cnt_q;
  logic       run_q;
  // Other conversions hold the engine busy too
  assign busy_o = run_q | hold_i;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      run_q  <= 1'b0;
      cnt_q  <= 8'h00;
      done_o <= 1'b0;
    end else begin
      done_o <= run_q && cnt_q == 8'h01;
      if (start_i) begin
        run_q <= 1'b1;
        cnt_q <= lat_i;
      end else if (run_q) begin
        cnt_q <= cnt_q - 8'h01;
        if (cnt_q == 8'h01) run_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== aptc_tb_top.sv ====
// Testbench for the pair trigger control block
`default_nettype none
module aptc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk_i, nrst_i, reg_wr_i, reg_rd_i, hold_q;
  logic                    eng_busy_i, eng_done_i, eng_start_o, irq_o;
  logic [3:0]              reg_addr_i, pair_irq_o;
  logic [15:0]             reg_wdata_i, reg_rdata_o;
  logic [1:0]              eng_pair_o;
  logic [7:0]              lat_q, b;
  aptc_pkg::aptc_trig_type trig_i;
  int                      n_fail, cmp_count, c;
  aptc_top i_dut (.*);
  aptc_eng_model i_eng (.clk_i(clk_i), .nrst_i(nrst_i), .start_i(eng_start_o),
    .hold_i(hold_q), .lat_i(lat_q), .busy_o(eng_busy_i), .done_o(eng_done_i));
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, exp, input string nm);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input string n);
    @(posedge clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    chk(reg_rdata_o, e, n);
  endtask
  task automatic pulse(input aptc_pkg::aptc_trig_type v);
    @(posedge clk_i);
    trig_i <= v;
    @(posedge clk_i);
    trig_i <= '0;
  endtask
  // Bounded wait for one done request, then compare it
  task automatic wait_irq(input logic [3:0] e);
    int i;
    i = 0;
    do begin
      @(negedge clk_i);
      i++;
    end while (pair_irq_o === 4'h0 && i < 300);
    chk({12'h000, pair_irq_o}, {12'h000, e}, "pair_irq");
    if (i >= 300) give_verdict();
  endtask
  // Bounded wait for a start pulse, then compare the pair it names
  task automatic wait_start(input logic [1:0] e);
    int i;
    i = 0;
    do begin
      @(negedge clk_i);
      i++;
    end while (eng_start_o !== 1'b1 && i < 300);
    chk({14'h0000, eng_pair_o}, {14'h0000, e}, "start_pair");
    if (i >= 300) begin
      n_fail++;
      give_verdict();
    end
  endtask
  function automatic aptc_pkg::aptc_trig_type trig_of(input int k);
    trig_of = '0;
    if (k == 2) trig_of.soft_global = 1'b1;
    if (k == 3) trig_of.pwm_special = 1'b1;
    if (k == 12) trig_of.timer1_match = 1'b1;
    if (k == 13) trig_of.pwm_sec_special = 1'b1;
    if (k == 31) trig_of.timer2_match = 1'b1;
    if (k >= 4 && k <= 11) trig_of.pwm_primary[k-4] = 1'b1;
    if (k >= 14 && k <= 22) trig_of.pwm_secondary[k-14] = 1'b1;
    if (k >= 23 && k <= 30) trig_of.pwm_cur_limit[k-23] = 1'b1;
  endfunction
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    nrst_i      = 1'b0;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    reg_addr_i  = 4'h0;
    reg_wdata_i = 16'h0000;
    hold_q      = 1'b0;
    lat_q       = 8'h14;
    trig_i      = '0;
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(4'h0, 16'h0000, "ctl_lower");
    rd(4'h1, 16'h0000, "ctl_upper");
    wr(4'hf, 16'hffff);
    rd(4'hf, 16'h0000, "unmapped");
    // Every code: all other sources must be ignored, its own must start
    for (c = 0; c < 32; c++) begin
      b = 8'h80 | 8'(c);
      wr(4'h0, {8'h00, b});
      pulse(~trig_of(c));
      rd(4'h0, {8'h00, b}, "stray_trig");
      if (c == 1) wr(4'h0, 16'h00a1);
      else if (c > 1) pulse(trig_of(c));
      if (c == 1) repeat (2) @(posedge clk_i);
      if (c == 1) rd(4'h0, 16'h00c1, "kick_clear");
      if (c > 0) wait_irq(4'h1);
      if (c > 0) rd(4'h0, {8'h00, b}, "wait_clear");
    end
    rd(4'h2, 16'h0001, "ready");
    wr(4'h2, 16'h0000);
    rd(4'h2, 16'h0000, "ready_clr");
    rd(4'h3, 16'h0001, "stat");
    rd(4'h3, 16'h0000, "stat_clr");
    chk({15'h0000, irq_o}, 16'h0000, "irq_masked");
    // All four pend while others convert; pair2 has no request enable
    @(posedge clk_i);
    hold_q <= 1'b1;
    lat_q  <= 8'h02;
    wr(4'h0, 16'h8383);
    wr(4'h1, 16'h8303);
    pulse(trig_of(3));
    rd(4'h0, 16'hc3c3, "held_lo");
    rd(4'h1, 16'hc343, "held_hi");
    @(posedge clk_i);
    hold_q <= 1'b0;
    wait_start(2'd0);
    wait_irq(4'h1);
    wait_start(2'd1);
    wait_irq(4'h2);
    wait_start(2'd2);
    wait_start(2'd3);
    wait_irq(4'h8);
    rd(4'h2, 16'h000f, "ready_all");
    wr(4'h4, 16'h0002);
    rd(4'h4, 16'h0002, "mask");
    chk({15'h0000, irq_o}, 16'h0001, "irq_on");
    rd(4'h3, 16'h000b, "stat_q");
    repeat (2) @(negedge clk_i);
    chk({15'h0000, irq_o}, 16'h0000, "irq_off");
    rd(4'h5, 16'h0019, "status");
    give_verdict();
  end
endmodule
`default_nettype wire
